// File: design/ee_defines.svh
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH
// Operation
// RL1 - sample data at clock rise, change output at clock fall
// RL2 - master opens each command with a start condition
// RL3 - start is watched always and restarts any transfer
// RL4 - a stop condition ends the current command
// RL5 - transfers are eight bits, each followed by acknowledge
// RL6 - receiver pulls data low in the ninth clock to acknowledge
// RL7 - matching slave address gets a low acknowledge
// RL8 - every word address and data byte of a write is acknowledged
// RL9 - reads continue on master ack, else wait for stop
// RL10 - upper four address bits must equal the device type code
// RL11 - next three bits compare with strapped device select pins
// RL12 - lowest address bit: 0 write, 1 read
// RL13 - some select positions become page select address bits
// RL14 - write data lands at the received word address
// RL15 - programming starts on stop after a complete data byte
// RL16 - all commands refused during the internal write time
// RL17 - page write takes up to one page of bytes together
// RL18 - only low address bits advance within a page
// RL19 - excess bytes wrap and overwrite the first ones
// RL20 - whole page programs in one write period
// RL21 - protect pin low from first data bit until programming ends; the code watches it from the eighth bit of the first data byte
// RL22 - protect high in that window cancels the write at once
// RL23 - protect high blocks programming of every location
// RL24 - no address acknowledge while programming
// RL25 - protect changes before first data bit are ignored
// RL26 - address mismatch releases data and idles until next start
// RL27 - data line is only pulled low or released

// register offsets
`define EE_REG_CTRL     8'h00
`define EE_REG_STATUS   8'h04
`define EE_REG_MEM_ADDR 8'h08
`define EE_REG_MEM_DATA 8'h0C
// field positions
`define EE_CTRL_EN      0
`define EE_ST_BUSY      0
`define EE_ST_DONE      1
`define EE_ST_CANCEL    2
// reset values
`define EE_CTRL_RST     1'b1
// timing
`define EE_CLK_KHZ      40000
`define EE_TWR_MS       5
`endif

// File: design/ee_pkg.sv
package ee_pkg;
    // protocol states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_WDATA,
        ST_RDATA,
        ST_WSTOP
    } ee_state_t;
endpackage

// File: design/ee_i2c_slave.sv
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`include "ee_defines.svh"

module ee_i2c_slave
    import ee_pkg::*;
#(
    parameter int         MEM_AW     = 8,
    parameter int         PAGE_BITS  = 3,
    parameter int         WORD_BYTES = 1,
    parameter int         PSEL_BITS  = 0,
    parameter int         TWR_CYC    = `EE_TWR_MS * `EE_CLK_KHZ,
    parameter logic [3:0] TYPE_CODE  = 4'h5 // arbitrary value
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // two-wire bus
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // straps and protect
    input  wire logic        wp,
    input  wire logic        device_select_pin_0,
    input  wire logic        device_select_pin_1,
    input  wire logic        device_select_pin_2
);
    localparam int PAGE = 1 << PAGE_BITS;
    localparam int MEMN = 1 << MEM_AW;
    localparam int TW   = $clog2(TWR_CYC + 1);
    localparam logic [2:0] SEL_MASK = 3'(3'h7 << PSEL_BITS);

    // ----------------------------------------
    // state
    // ----------------------------------------
    ee_state_t      state_q;
    logic [3:0]     bit_q;
    logic [7:0]     rx_q;
    logic [7:0]     tx_q;
    logic           ack_en_q;
    logic [15:0]    word_q;
    logic [2:0]     psel_q;
    logic           armed_q;
    logic           busy_q;
    logic [TW-1:0]  twr_q;
    logic [7:0]     mem_q [MEMN];
    logic [7:0]     pbuf_q [PAGE];
    logic [PAGE-1:0] pval_q;
    logic           en_q;
    logic           done_q;
    logic           cancel_q;
    logic [MEM_AW-1:0] dbg_addr_q;
    logic           wr_pend_q;
    logic [7:0]     bus_addr_q;
    logic           scl_m, scl_s, scl_p;
    logic           sda_m, sda_s, sda_p;
    logic           wp_m, wp_s;
    logic [2:0]     pins_m, pins_s;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_p <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_p <= 1'b1;
            wp_m  <= 1'b0;
            wp_s  <= 1'b0;
            pins_m <= 3'h0;
            pins_s <= 3'h0;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            scl_p <= scl_s;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sda_p <= sda_s;
            wp_m  <= wp;
            wp_s  <= wp_m;
            pins_m <= {device_select_pin_2, device_select_pin_1,
                       device_select_pin_0};
            pins_s <= pins_m;
        end
    end

    // ----------------------------------------
    // bus conditions and decode
    // ----------------------------------------
    logic scl_rise, scl_fall, start_det, stop_det;
    logic byte_done, wr_byte, dev_match, rx_cancel;
    logic busy_cancel, prog_go, prog_end;
    logic [7:0] rx_byte;
    logic [2:0] pins;
    logic [MEM_AW-1:0] mem_a, page_base;

    // edges seen on the synchronised clock line
    assign scl_rise  = scl_s & ~scl_p;
    assign scl_fall  = ~scl_s & scl_p;
    // data moving while clock high marks start and stop
    assign start_det = scl_s & scl_p & sda_p & ~sda_s; // see RL3
    assign stop_det  = scl_s & scl_p & ~sda_p & sda_s; // see RL4
    assign rx_byte   = {rx_q[6:0], sda_s};
    assign pins      = pins_s;
    assign byte_done = scl_rise && bit_q == 4'h7 &&
                       state_q != ST_IDLE && state_q != ST_WSTOP;
    // type code, then unmasked select bits
    assign dev_match = rx_byte[7:4] == TYPE_CODE && // see RL10
                       ((rx_byte[3:1] ^ pins) & SEL_MASK) == 3'h0; // see RL11
    assign wr_byte   = byte_done && state_q == ST_WDATA;
    // protect only counts from the eighth bit of the first data byte on
    assign rx_cancel = state_q == ST_WDATA && wp_s &&
                       (armed_q || wr_byte); // see RL22 RL25
    assign busy_cancel = busy_q && wp_s; // see RL22
    // the clock rise ahead of a stop counts one bit past the ack slot
    assign prog_go   = stop_det && state_q == ST_WDATA && armed_q &&
                       bit_q == 4'h1 && !wp_s; // see RL15 RL23
    assign prog_end  = busy_q && twr_q == TW'(1);
    // page select sits above the word address
    assign mem_a = (WORD_BYTES == 2) ? MEM_AW'({psel_q, word_q}) :
                   MEM_AW'({psel_q, word_q[7:0]}); // see RL13 RL14
    assign page_base = mem_a & ~MEM_AW'(PAGE - 1);

    // ----------------------------------------
    // serial protocol engine
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q  <= ST_IDLE;
            bit_q    <= 4'h0;
            rx_q     <= 8'h00;
            tx_q     <= 8'h00;
            ack_en_q <= 1'b0;
            word_q   <= 16'h0000;
            psel_q   <= 3'h0;
            armed_q  <= 1'b0;
            sda_oe   <= 1'b0;
        end else if (start_det) begin
            state_q  <= ST_DEV; // see RL3
            bit_q    <= 4'h0;
            sda_oe   <= 1'b0;
            armed_q  <= 1'b0;
            ack_en_q <= 1'b0;
        end else if (stop_det || rx_cancel) begin
            state_q  <= ST_IDLE; // see RL4
            sda_oe   <= 1'b0;
            armed_q  <= 1'b0;
            ack_en_q <= 1'b0;
        end else begin
            // rising clock: sample input bit
            if (scl_rise && state_q != ST_IDLE &&
                state_q != ST_WSTOP) begin
                if (bit_q != 4'h8) begin
                    rx_q  <= rx_byte; // see RL1
                    bit_q <= bit_q + 4'h1;
                end else begin
                    bit_q <= 4'h0; // see RL5
                    if (state_q == ST_RDATA && sda_s) begin
                        state_q <= ST_WSTOP; // see RL9
                    end
                end
            end
            // eighth bit in: act on the byte
            if (byte_done) begin
                ack_en_q <= 1'b1; // see RL8
                unique case (state_q)
                    ST_DEV: begin
                        if (dev_match && !busy_q && en_q) begin
                            psel_q <= rx_byte[3:1] & ~SEL_MASK;
                            if (rx_byte[0]) begin // see RL12
                                state_q <= ST_RDATA;
                            end else if (WORD_BYTES == 2) begin
                                state_q <= ST_ADDR_HI;
                            end else begin
                                state_q <= ST_ADDR_LO;
                            end
                        end else begin
                            ack_en_q <= 1'b0; // see RL24 RL26
                            state_q  <= ST_IDLE;
                        end
                    end
                    ST_ADDR_HI: begin
                        word_q[15:8] <= rx_byte;
                        state_q      <= ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        word_q[7:0] <= rx_byte;
                        state_q     <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        armed_q <= 1'b1; // see RL21
                        // low bits wrap inside the page
                        word_q[PAGE_BITS-1:0] <=
                            word_q[PAGE_BITS-1:0] +
                            PAGE_BITS'(1); // see RL18 RL19
                    end
                    ST_RDATA: ack_en_q <= 1'b0;
                    default:  ack_en_q <= 1'b0;
                endcase
            end
            // falling clock: change output
            if (scl_fall) begin
                if (bit_q == 4'h8) begin
                    sda_oe <= ack_en_q; // see RL6 RL7
                end else if (bit_q == 4'h0) begin
                    if (state_q == ST_RDATA) begin
                        tx_q   <= mem_q[mem_a];
                        sda_oe <= ~mem_q[mem_a][7]; // see RL1
                        word_q <= word_q + 16'h0001;
                    end else begin
                        sda_oe <= 1'b0;
                    end
                end else begin
                    tx_q   <= {tx_q[6:0], 1'b0};
                    sda_oe <= state_q == ST_RDATA && !tx_q[6];
                end
            end
        end
    end

    // data line is never driven high
    always_ff @(posedge ref_clk) begin
        sda_o <= 1'b0; // see RL27
    end

    // ----------------------------------------
    // page buffer
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pval_q <= '0;
        end else if (byte_done && state_q == ST_ADDR_LO) begin
            pval_q <= '0;
        end else if (wr_byte) begin
            pbuf_q[word_q[PAGE_BITS-1:0]] <= rx_byte; // see RL17 RL19
            pval_q[word_q[PAGE_BITS-1:0]] <= 1'b1;
        end
    end

    // ----------------------------------------
    // internal write timer and commit
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busy_q <= 1'b0;
            twr_q  <= '0;
        end else if (prog_go) begin
            busy_q <= 1'b1; // see RL15
            twr_q  <= TW'(TWR_CYC); // see RL16 RL20
        end else if (busy_cancel || prog_end) begin
            busy_q <= 1'b0; // see RL22
            twr_q  <= '0;
        end else if (busy_q) begin
            twr_q <= twr_q - TW'(1);
        end
    end

    // all latched bytes land together at the end
    always_ff @(posedge ref_clk) begin
        if (prog_end && !wp_s) begin
            for (int i = 0; i < PAGE; i++) begin
                if (pval_q[i]) begin
                    mem_q[page_base | MEM_AW'(i)] <= pbuf_q[i]; // see RL20
                end
            end
        end
    end

    // ----------------------------------------
    // register slave
    // ----------------------------------------
    logic ahb_go, clr_done, clr_cancel;
    assign ahb_go     = hsel && htrans[1] && hready;
    assign clr_done   = wr_pend_q && bus_addr_q == `EE_REG_STATUS &&
                        hwdata[`EE_ST_DONE];
    assign clr_cancel = wr_pend_q && bus_addr_q == `EE_REG_STATUS &&
                        hwdata[`EE_ST_CANCEL];

    // address phase capture and read data
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_pend_q  <= 1'b0;
            bus_addr_q <= 8'h00;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else begin
            wr_pend_q  <= ahb_go && hwrite;
            bus_addr_q <= haddr[7:0];
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            if (ahb_go && !hwrite) begin
                unique case (haddr[7:0])
                    `EE_REG_CTRL:     hrdata <= {31'h0, en_q};
                    `EE_REG_STATUS:   hrdata <= {29'h0, cancel_q,
                                                 done_q, busy_q};
                    `EE_REG_MEM_ADDR: hrdata <= 32'(dbg_addr_q);
                    `EE_REG_MEM_DATA: hrdata <= {24'h0,
                                                 mem_q[dbg_addr_q]};
                    default:          hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // data phase writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            en_q       <= `EE_CTRL_RST;
            dbg_addr_q <= '0;
        end else if (wr_pend_q) begin
            if (bus_addr_q == `EE_REG_CTRL) begin
                en_q <= hwdata[`EE_CTRL_EN];
            end
            if (bus_addr_q == `EE_REG_MEM_ADDR) begin
                dbg_addr_q <= hwdata[MEM_AW-1:0];
            end
        end
    end

    // sticky flags, the event wins over the clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            done_q   <= 1'b0;
            cancel_q <= 1'b0;
        end else begin
            done_q   <= (prog_end && !wp_s) || (done_q && !clr_done);
            cancel_q <= rx_cancel || busy_cancel ||
                        (cancel_q && !clr_cancel);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    never_high_a: assert property ( // see RL27
        sda_oe |-> !sda_o) else $error("sda driven high");
    oe_on_fall_a: assert property ( // see RL1
        $changed(sda_oe) |-> $past(scl_fall || start_det ||
                                   stop_det || rx_cancel))
        else $error("sda changed off the falling clock");
    start_restart_a: assert property ( // see RL3
        start_det |=> state_q == ST_DEV && bit_q == 4'h0 && !sda_oe)
        else $error("start did not restart");
    stop_end_a: assert property ( // see RL4
        stop_det |=> state_q == ST_IDLE && !sda_oe)
        else $error("stop did not end command");
    busy_nack_a: assert property ( // see RL24
        byte_done && state_q == ST_DEV && busy_q |=> !ack_en_q)
        else $error("address acked while busy");
    mismatch_idle_a: assert property ( // see RL26
        byte_done && state_q == ST_DEV && !dev_match
        |=> state_q == ST_IDLE ##1 !sda_oe)
        else $error("mismatch not idled");
    prog_cause_a: assert property ( // see RL15
        $rose(busy_q) |-> $past(stop_det && armed_q))
        else $error("programming without stop");
    busy_hold_a: assert property ( // see RL16
        busy_q && !wp_s && twr_q != TW'(1) |=> busy_q)
        else $error("busy too short");
    wp_abort_a: assert property ( // see RL22
        busy_q && wp_s |=> !busy_q) else $error("cancel missed");
    page_wrap_a: assert property ( // see RL18
        wr_byte && !rx_cancel |=> word_q[PAGE_BITS-1:0] ==
            PAGE_BITS'($past(word_q[PAGE_BITS-1:0]) + 1) &&
            word_q[15:PAGE_BITS] == $past(word_q[15:PAGE_BITS]))
        else $error("page address wrong");
    ack_slot_a: assert property ( // see RL6
        scl_fall && bit_q == 4'h8 && ack_en_q && !start_det &&
        !stop_det && !rx_cancel |=> sda_oe)
        else $error("ack not driven");

    write_cov_c:  cover property (prog_end && !wp_s);
    read_cov_c:   cover property (state_q == ST_RDATA && scl_fall);
    cancel_cov_c: cover property (busy_cancel);
endmodule

// File: verif/ee_i2c_master_model.sv
module ee_i2c_master_model (
    // clock
    input  wire logic ref_clk,
    // two-wire bus
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // bus master: scl stands high between frames
    // ----------------------------------------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // sda falls while scl high
    task automatic start();
        tick(2);
        sda_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(2);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask

    // sda rises while scl high
    task automatic stop();
        tick(2);
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(2);
        sda_low <= 1'b0;
        tick(4);
    endtask

    // change data while scl low, sample just before scl falls
    task automatic xfer_bit(input logic b, output logic r);
        tick(2);
        sda_low <= !b;
        tick(2);
        scl <= 1'b1;
        tick(4);
        r = sda;
        scl <= 1'b0;
    endtask

    // eight bits msb first, then release for the ninth
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(b[i], r);
        xfer_bit(1'b1, r);
        ack = !r;
    endtask

    // read a byte, pull low on the ninth to continue
    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            xfer_bit(1'b1, r);
            d = {d[6:0], r};
        end
        xfer_bit(!more, r);
    endtask
endmodule

// File: verif/tb_i2c_eeprom_slave_write_path.sv
`include "ee_defines.svh"

module tb_i2c_eeprom_slave_write_path;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [3:0] TYPE = 4'h5; // arbitrary value

    logic        ref_clk = 1'b0;
    logic        reset, hsel, hwrite, wp, sda_o, sda_oe, scl, mst_low;
    logic        hreadyout, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize, sel;
    logic [31:0] haddr, hwdata, hrdata, seed = 32'hF464;
    logic [7:0]  exp_mem [256];
    int          failures = 0, n_checks = 0, cyc = 0;
    wire         sda_bus = !((sda_oe && !sda_o) || mst_low);

    ee_i2c_slave #(.TWR_CYC(200), .TYPE_CODE(TYPE)) u_dut (
        .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .scl_i(scl), .sda_i(sda_bus),
        .sda_o(sda_o), .sda_oe(sda_oe), .wp(wp),
        .device_select_pin_0(sel[0]), .device_select_pin_1(sel[1]),
        .device_select_pin_2(sel[2])
    );

    ee_i2c_master_model u_mst (
        .ref_clk(ref_clk), .sda(sda_bus), .scl(scl), .sda_low(mst_low)
    );

    // ----------------------------------------
    // clock, timeout, helpers
    // ----------------------------------------
    always #12.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (sda_oe === 1'b1 && sda_o !== 1'b0) begin
            failures++;
            $display("unexpected at %0t: sda_o %h exp %h", $time,
                     sda_o, 1'b0);
        end
        cyc++;
        if (cyc == 60000) begin
            failures++;
            $display("unexpected at %0t: timeout %h exp %h", $time,
                     cyc, 0);
            end_sim();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] dev(input logic rw);
        return {TYPE, sel, rw};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one single ahb transfer, zero or more wait states
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk_mem(input logic [7:0] a);
        logic [31:0] r;
        ahb(1'b1, `EE_REG_MEM_ADDR, {24'h0, a}, r);
        ahb(1'b0, `EE_REG_MEM_DATA, 32'h0, r);
        chk(r, {24'h0, exp_mem[a]});
    endtask

    // poll busy; bound is 90 polls of about 3 cycles each, near 270 cycles against a 200-cycle write period
    task automatic wait_idle();
        logic [31:0] r;
        int k;
        k = 0;
        do begin
            ahb(1'b0, `EE_REG_STATUS, 32'h0, r);
            k++;
        end while (r[0] !== 1'b0 && k < 90);
        chk(32'(k < 90), 32'h1);
    endtask

    // m: 0 plain, 1 protect during address only, 2 protect throughout
    task automatic write_seq(input logic [7:0] wa, input int n, input int m);
        logic ack;
        logic [7:0] d;
        if (m > 0) wp <= 1'b1;
        u_mst.start();
        u_mst.wr_byte(dev(1'b0), ack);
        chk(32'(ack), 32'h1);
        u_mst.wr_byte(wa, ack);
        chk(32'(ack), 32'h1);
        if (m == 1) wp <= 1'b0;
        for (int i = 0; i < n; i++) begin
            d = 8'(rnd());
            u_mst.wr_byte(d, ack);
            chk(32'(ack), 32'(m != 2));
            if (m != 2) exp_mem[{wa[7:3], wa[2:0] + 3'(i)}] = d;
        end
        u_mst.stop();
    endtask

    task automatic poll(input logic exp_ack);
        logic ack;
        u_mst.start();
        u_mst.wr_byte(dev(1'b0), ack);
        chk(32'(ack), 32'(exp_ack));
        u_mst.stop();
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        logic [7:0]  wa, d;
        logic        ack;
        {hsel, hwrite, wp, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        sel = 3'(rnd());
        reset = 1'b1;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        chk({hreadyout, hresp, sda_oe}, 32'h4);
        ahb(1'b0, `EE_REG_CTRL, 32'h0, r);
        chk(r, 32'h1);
        ahb(1'b1, 8'h10, 32'hFFFF_FFFF, r);
        ahb(1'b0, 8'h10, 32'h0, r);
        chk(r, 32'h0);
        // byte write, refused while busy, then accepted
        wa = 8'(rnd());
        write_seq(wa, 1, 0);
        ahb(1'b0, `EE_REG_STATUS, 32'h0, r);
        chk(r, 32'h1);
        poll(1'b0);
        wait_idle();
        ahb(1'b0, `EE_REG_STATUS, 32'h0, r);
        chk(r, 32'h2);
        ahb(1'b1, `EE_REG_STATUS, 32'h7, r);
        chk_mem(wa);
        poll(1'b1);
        // page write of ten bytes wraps inside an eight byte page
        wa = 8'(rnd());
        write_seq(wa, 10, 0);
        wait_idle();
        for (int i = 0; i < 8; i++) chk_mem({wa[7:3], 3'(i)});
        // random read through repeated start, ack then no ack
        wa = {wa[7:3], 3'b000};
        u_mst.start();
        u_mst.wr_byte(dev(1'b0), ack);
        u_mst.wr_byte(wa, ack);
        u_mst.start();
        u_mst.wr_byte(dev(1'b1), ack);
        chk(32'(ack), 32'h1);
        u_mst.rd_byte(1'b1, d);
        chk(32'(d), 32'(exp_mem[wa]));
        u_mst.rd_byte(1'b0, d);
        chk(32'(d), 32'(exp_mem[wa + 8'h1]));
        u_mst.stop();
        // wrong type code or select pins: no ack, stays idle
        for (int k = 0; k < 4; k++) begin
            u_mst.start();
            if (k == 3) d = {TYPE ^ 4'h8, sel, 1'b0};
            else d = {TYPE, sel ^ 3'(1 << k), 1'b0};
            u_mst.wr_byte(d, ack);
            chk(32'(ack), 32'h0);
            u_mst.wr_byte(8'h00, ack);
            chk(32'(ack), 32'h0);
            u_mst.stop();
        end
        // disabled device ignores its address
        ahb(1'b1, `EE_REG_CTRL, 32'h0, r);
        poll(1'b0);
        ahb(1'b1, `EE_REG_CTRL, 32'h1, r);
        // protect during address only is ignored
        wa = 8'(rnd());
        write_seq(wa, 1, 1);
        wait_idle();
        chk_mem(wa);
        // protect throughout blocks the write
        write_seq(wa ^ 8'h80, 1, 2);
        wp <= 1'b0;
        ahb(1'b0, `EE_REG_STATUS, 32'h0, r);
        chk(32'(r[2]), 32'h1);
        ahb(1'b1, `EE_REG_STATUS, 32'h7, r);
        // protect raised while programming cancels at once
        write_seq(wa, 1, 0);
        wp <= 1'b1;
        repeat (20) @(posedge ref_clk);
        wp <= 1'b0;
        ahb(1'b0, `EE_REG_STATUS, 32'h0, r);
        chk(32'(r[2:0]), 32'h4);
        poll(1'b1);
        end_sim();
    end
endmodule
